// [logic/fnd_pkg.sv]
// constants shared by the fractional-n divider and modulation control
package fnd_pkg;
  // ----------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_REF = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_MOD = 8'h08;
  localparam logic [7:0] ADDR_FUN = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_LAST_LATCH = 8'h0c;
  // ----------------------------------------
  // serial word and latch selects
  // ----------------------------------------
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_DIV = 2'h1;
  localparam logic [1:0] SEL_MOD = 2'h2;
  localparam logic [1:0] SEL_FUN = 2'h3;
  localparam logic [23:0] REG_RESET = 24'h000000;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CORR_LSB = 2;
  localparam int CORR_W = 11;
  localparam int FRAC_LSB = 2;
  localparam int FRAC_W = 12;
  localparam int INT_LSB = 14;
  localparam int INT_W = 8;
  localparam int PRESC_BIT = 22;
  localparam int SCHEME_LO_BIT = 2;
  localparam int SCHEME_HI_BIT = 3;
  localparam int HIPWR_LSB = 4;
  localparam int LOLVL_LSB = 11;
  localparam int LEVEL_W = 7;
  localparam int GEXP_LSB = 18;
  localparam int GEXP_W = 3;
  localparam int DIVF_LSB = 2;
  localparam int DIVF_W = 8;
  localparam int IDX_LSB = 10;
  localparam int IDX_W = 7;
  localparam int STAT_CLR_BIT = 0;
  // ----------------------------------------
  // divider arithmetic
  // ----------------------------------------
  localparam int ACC_W = 15;
  localparam int FRAC_SHIFT = 3;
  localparam logic [7:0] PRESC_SMALL = 8'h04;
  localparam logic [7:0] PRESC_LARGE = 8'h08;
  // ----------------------------------------
  // modulation schemes {hi, lo}
  // ----------------------------------------
  typedef enum logic [1:0] {
    FND_FSK = 2'h0,
    FND_GFSK = 2'h1,
    FND_ASK = 2'h2,
    FND_OOK = 2'h3
  } fnd_scheme_t;
endpackage : fnd_pkg

// [logic/fnd_core.sv]
// fractional-n divider control, modulation keying, serial load path and fifo
// Overview of operation
// - fifteen-bit sigma-delta fractional feedback divider
// - prescaler four/five or eight/nine, minimum N
// - eight-bit integer, minimum up to 255
// - fraction plus signed correction forms fifteen bits
// - output equals pfd times weighted sum
// - fraction and correction lsb step sizes
// - correction defaults zero, software writable signed
// - fsk offsets divider by modulation number
// - both select bits zero picks fsk
// - gfsk prefilters data, drives bit clock
// - gfsk deviation two to exponent
// - bit clock rate pfd over factor*index
// - ask feeds low or high field
// - hi one lo zero picks ask
// - ook high field or output off
// - both select bits one picks ook
// - 24-bit words msb first, load strobe
// - two lsbs select destination latch
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module fnd_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_rdy;
    logic out_vld;
  } fnd_fifo_t;
  fnd_fifo_t s_ff;
  fnd_fifo_t nxt_s;
  logic push;
  logic pop;

  always_comb begin
    nxt_s = s_ff;
    push = in_valid && s_ff.in_rdy;
    pop = out_ready && s_ff.out_vld;
    if (push) begin
      nxt_s.mem[s_ff.wp] = in_data;
      nxt_s.wp = (s_ff.wp == LAST) ? '0 : s_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_s.rp = (s_ff.rp == LAST) ? '0 : s_ff.rp + 1'b1;
    end
    nxt_s.cnt = s_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    // full and empty track the next count so back-pressure is exact
    nxt_s.in_rdy = (nxt_s.cnt != FULL);
    nxt_s.out_vld = (nxt_s.cnt != '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{mem: '0, wp: '0, rp: '0, cnt: '0, in_rdy: 1'b1, out_vld: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign in_ready = s_ff.in_rdy;
  assign out_valid = s_ff.out_vld;
  assign out_data = s_ff.mem[s_ff.rp];
endmodule : fnd_fifo

module fnd_core #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  output logic word_accept,
  input wire logic tx_bit_in,
  input wire logic pfd_tick,
  output logic tx_bit_clock_out,
  output logic [7:0] n_inst,
  output logic [6:0] dac_code,
  output logic pa_enable
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [3:0][23:0] regs;
    logic [23:0] shift;
    logic sclk_q;
    logic load_q;
    logic overrun;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic [14:0] acc;
    logic [7:0] n_inst;
    logic [6:0] dac;
    logic pa_on;
    logic bclk;
    logic [14:0] bcnt;
    logic [2:0] hist;
  } fnd_state_t;
  fnd_state_t s_ff;
  fnd_state_t nxt_s;

  function automatic logic [7:0] min_n(input logic big);
    logic [7:0] p;
    p = big ? fnd_pkg::PRESC_LARGE : fnd_pkg::PRESC_SMALL;
    min_n = 8'(p * p + 8'h03 * p + 8'h03);
  endfunction : min_n

  logic [23:0] fifo_word;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_ready;
  logic load_rise;
  logic apb_setup;
  logic apb_wr;
  logic mapped;
  fnd_pkg::fnd_scheme_t scheme;
  logic [10:0] corr;
  logic [11:0] frac;
  logic [7:0] int_n;
  logic presc_big;
  logic [6:0] hi_pwr;
  logic [6:0] lo_lvl;
  logic [2:0] gexp;
  logic [14:0] period;
  logic signed [3:0] filt;
  logic signed [15:0] off;
  logic signed [24:0] total;
  logic [15:0] acc_sum;
  logic [7:0] n_raw;
  logic bit_tick;

  fnd_fifo #(
    .WIDTH(fnd_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(load_rise),
    .in_ready(fifo_ready),
    .in_data(s_ff.shift),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  always_comb begin
    nxt_s = s_ff;
    // ----------------------------------------
    // serial port
    // ----------------------------------------
    nxt_s.sclk_q = serial_clk;
    nxt_s.load_q = load_strobe;
    if (serial_clk && !s_ff.sclk_q) begin
      nxt_s.shift = {s_ff.shift[22:0], serial_data};
    end
    load_rise = load_strobe && !s_ff.load_q;
    // a word arriving on a full fifo is lost, so flag it
    if (load_rise && !fifo_ready) begin
      nxt_s.overrun = 1'b1;
    end
    // ----------------------------------------
    // apb slave, one wait-free access cycle
    // ----------------------------------------
    apb_setup = psel && !penable;
    apb_wr = psel && penable && s_ff.rdy && pwrite;
    mapped = (paddr[1:0] == 2'h0) && (paddr <= fnd_pkg::ADDR_STAT);
    nxt_s.rdy = apb_setup;
    nxt_s.err = apb_setup && !mapped;
    nxt_s.rdata = '0;
    if (apb_setup && !pwrite && mapped) begin
      if (paddr == fnd_pkg::ADDR_STAT) begin
        nxt_s.rdata = {7'h00, fifo_valid, s_ff.overrun, s_ff.pa_on, s_ff.bclk,
                       s_ff.dac, s_ff.n_inst, 5'h00, fifo_ready};
      end else begin
        nxt_s.rdata = {8'h00, s_ff.regs[paddr[3:2]]};
      end
    end
    if (apb_wr && !s_ff.err && paddr <= fnd_pkg::ADDR_LAST_LATCH) begin
      nxt_s.regs[paddr[3:2]] = pwdata[23:0];
    end
    // clear wins only without a same-cycle overrun
    if (apb_wr && !s_ff.err && paddr == fnd_pkg::ADDR_STAT
        && pwdata[fnd_pkg::STAT_CLR_BIT] && !(load_rise && !fifo_ready)) begin
      nxt_s.overrun = 1'b0;
    end
    // fifo drains only when the bus is not in a write access cycle, whatever the address
    fifo_pop = !apb_wr;
    // low two bits pick the latch
    if (fifo_pop && fifo_valid) begin
      nxt_s.regs[fifo_word[1:0]] = fifo_word;
    end
    // ----------------------------------------
    // field decode
    // ----------------------------------------
    corr = s_ff.regs[fnd_pkg::SEL_REF][fnd_pkg::CORR_LSB +: fnd_pkg::CORR_W];
    frac = s_ff.regs[fnd_pkg::SEL_DIV][fnd_pkg::FRAC_LSB +: fnd_pkg::FRAC_W];
    int_n = s_ff.regs[fnd_pkg::SEL_DIV][fnd_pkg::INT_LSB +: fnd_pkg::INT_W];
    presc_big = s_ff.regs[fnd_pkg::SEL_DIV][fnd_pkg::PRESC_BIT];
    scheme = fnd_pkg::fnd_scheme_t'({s_ff.regs[fnd_pkg::SEL_MOD][fnd_pkg::SCHEME_HI_BIT],
                                     s_ff.regs[fnd_pkg::SEL_MOD][fnd_pkg::SCHEME_LO_BIT]});
    hi_pwr = s_ff.regs[fnd_pkg::SEL_MOD][fnd_pkg::HIPWR_LSB +: fnd_pkg::LEVEL_W];
    lo_lvl = s_ff.regs[fnd_pkg::SEL_MOD][fnd_pkg::LOLVL_LSB +: fnd_pkg::LEVEL_W];
    gexp = s_ff.regs[fnd_pkg::SEL_MOD][fnd_pkg::GEXP_LSB +: fnd_pkg::GEXP_W];
    period = 15'(s_ff.regs[fnd_pkg::SEL_FUN][fnd_pkg::DIVF_LSB +: fnd_pkg::DIVF_W]
                 * s_ff.regs[fnd_pkg::SEL_FUN][fnd_pkg::IDX_LSB +: fnd_pkg::IDX_W]);
    // ----------------------------------------
    // gfsk bit clock and prefilter
    // ----------------------------------------
    bit_tick = 1'b0;
    if (scheme == fnd_pkg::FND_GFSK) begin
      // bit period is factor times index pfd cycles
      if (pfd_tick) begin
        if (s_ff.bcnt + 15'h0001 >= period) begin
          nxt_s.bcnt = '0;
          bit_tick = 1'b1;
        end else begin
          nxt_s.bcnt = s_ff.bcnt + 15'h0001;
        end
      end
      // bit clock high in first half of the bit
      nxt_s.bclk = (nxt_s.bcnt < (period >> 1));
      if (bit_tick) begin
        nxt_s.hist = {s_ff.hist[1:0], tx_bit_in};
      end
    end else begin
      nxt_s.bcnt = '0;
      nxt_s.bclk = 1'b0;
    end
    // 1-2-1 taps; each tap contributes +w for a one and -w for a zero
    filt = (s_ff.hist[0] ? 4'sd1 : -4'sd1) + (s_ff.hist[1] ? 4'sd2 : -4'sd2)
           + (s_ff.hist[2] ? 4'sd1 : -4'sd1);
    // ----------------------------------------
    // frequency offset in 2^-15 units
    // ----------------------------------------
    case (scheme)
      // fsk deviation = number / 2^12
      fnd_pkg::FND_FSK: begin
        off = tx_bit_in ? 16'sd0 + 16'({lo_lvl, 3'h0}) : 16'sd0 - 16'({lo_lvl, 3'h0});
      end
      // full filter swing is 2^m / 2^12
      fnd_pkg::FND_GFSK: begin
        off = 16'(16'(filt) <<< ({1'b0, gexp} + 4'h1));
      end
      default: begin
        off = 16'sd0;
      end
    endcase
    total = 25'({int_n, 15'h0000}) + 25'({frac, 3'h0})
            + 25'(signed'(corr)) + 25'(off);
    // first-order accumulator, one step per pfd cycle
    acc_sum = {1'b0, s_ff.acc} + {1'b0, total[fnd_pkg::ACC_W-1:0]};
    n_raw = 8'(total[22:15] + 8'(acc_sum[15]));
    if (pfd_tick) begin
      nxt_s.acc = acc_sum[14:0];
      nxt_s.n_inst = (n_raw < min_n(presc_big)) ? min_n(presc_big) : n_raw;
    end
    // ----------------------------------------
    // output level keying
    // ----------------------------------------
    case (scheme)
      fnd_pkg::FND_ASK: begin
        nxt_s.dac = tx_bit_in ? hi_pwr : lo_lvl;
        nxt_s.pa_on = 1'b1;
      end
      fnd_pkg::FND_OOK: begin
        nxt_s.dac = tx_bit_in ? hi_pwr : 7'h00;
        nxt_s.pa_on = tx_bit_in;
      end
      default: begin
        nxt_s.dac = hi_pwr;
        nxt_s.pa_on = 1'b1;
      end
    endcase
  end

  // correction resets to zero with every latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{regs: {4{fnd_pkg::REG_RESET}}, shift: '0, sclk_q: 1'b0, load_q: 1'b0,
                overrun: 1'b0, rdata: '0, rdy: 1'b0, err: 1'b0, acc: '0,
                n_inst: '0, dac: '0, pa_on: 1'b0, bclk: 1'b0, bcnt: '0, hist: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.rdata;
  assign pready = s_ff.rdy;
  assign pslverr = s_ff.err;
  assign word_accept = fifo_ready;
  assign tx_bit_clock_out = s_ff.bclk;
  assign n_inst = s_ff.n_inst;
  assign dac_code = s_ff.dac;
  assign pa_enable = s_ff.pa_on;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_drain_div;
    fifo_pop && fifo_valid && fifo_word[1:0] == fnd_pkg::SEL_DIV;
  endsequence

  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn) s_setup |=> pready
      ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");

  property p_latch_div;
    @(posedge pclk) disable iff (!presetn)
      s_drain_div |=> s_ff.regs[fnd_pkg::SEL_DIV] == $past(fifo_word);
  endproperty
  a_latch_div: assert property (p_latch_div) else $error("divider latch not loaded");

  property p_ask_level;
    @(posedge pclk) disable iff (!presetn)
      scheme == fnd_pkg::FND_ASK && !tx_bit_in |=> dac_code == $past(lo_lvl) && pa_enable;
  endproperty
  a_ask_level: assert property (p_ask_level) else $error("ask low level wrong");

  property p_ook_off;
    @(posedge pclk) disable iff (!presetn)
      scheme == fnd_pkg::FND_OOK |=> pa_enable == $past(tx_bit_in)
        && (pa_enable || dac_code == 7'h00);
  endproperty
  a_ook_off: assert property (p_ook_off) else $error("ook output not keyed");

  property p_fsk_high;
    @(posedge pclk) disable iff (!presetn)
      scheme == fnd_pkg::FND_FSK |=> dac_code == $past(hi_pwr);
  endproperty
  a_fsk_high: assert property (p_fsk_high) else $error("fsk power not high field");

  property p_n_floor;
    @(posedge pclk) disable iff (!presetn)
      pfd_tick |=> n_inst >= min_n($past(presc_big));
  endproperty
  a_n_floor: assert property (p_n_floor) else $error("divider below minimum");

  property p_n_hold;
    @(posedge pclk) disable iff (!presetn) !pfd_tick |=> $stable(n_inst);
  endproperty
  a_n_hold: assert property (p_n_hold) else $error("divider changed off pfd tick");

  property p_bclk_idle;
    @(posedge pclk) disable iff (!presetn)
      scheme != fnd_pkg::FND_GFSK |=> !tx_bit_clock_out;
  endproperty
  a_bclk_idle: assert property (p_bclk_idle) else $error("bit clock outside gfsk");

  property p_overrun;
    @(posedge pclk) disable iff (!presetn) load_rise && !fifo_ready |=> s_ff.overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("lost word not flagged");
endmodule : fnd_core

`default_nettype wire

// [sim/fnd_mcu.sv]
// microcontroller model: serial loader and transmit bit source
`timescale 1ns/1ps
`default_nettype none
module fnd_mcu (
  input wire logic pclk,
  input wire logic bit_clk,
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe,
  output logic tx_bit_in
);
  // ----------------------------------------
  // serial port and data pin driving
  // ----------------------------------------
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
    tx_bit_in = 1'b0;
  end
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      @(posedge pclk);
      serial_clk <= 1'b0;
      serial_data <= w[i];
      @(posedge pclk);
      serial_clk <= 1'b1;
    end
    @(posedge pclk);
    serial_clk <= 1'b0;
    // idle data shows the inverse so a stale bit is never mistaken for a held one
    serial_data <= ~w[0];
    load_strobe <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    load_strobe <= 1'b0;
  endtask : send_word
  task automatic send_sync(input logic b);
    @(posedge bit_clk);
    @(posedge pclk);
    tx_bit_in <= b;
  endtask : send_sync
  task automatic set_bit(input logic b);
    @(posedge pclk);
    tx_bit_in <= b;
  endtask : set_bit
endmodule : fnd_mcu
`default_nettype wire

// [sim/tb_top.sv]
// testbench for the fractional-n divider and modulation control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr, n_inst;
  logic [31:0] pwdata, prdata, rd;
  logic serial_clk, serial_data, load_strobe, word_accept, tx_bit_in;
  logic pfd_tick, tx_bit_clock_out, pa_enable;
  logic [6:0] dac_code;
  logic [1:0] ph;
  int err_count = 0;
  int samples_checked = 0;
  fnd_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clk(serial_clk), .serial_data(serial_data),
    .load_strobe(load_strobe), .word_accept(word_accept), .tx_bit_in(tx_bit_in),
    .pfd_tick(pfd_tick), .tx_bit_clock_out(tx_bit_clock_out), .n_inst(n_inst),
    .dac_code(dac_code), .pa_enable(pa_enable));
  fnd_mcu i_mcu (.pclk(pclk), .bit_clk(tx_bit_clock_out), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe), .tx_bit_in(tx_bit_in));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // phase-detector pulse every fourth cycle
  always @(posedge pclk) begin
    ph <= ph + 2'h1;
    pfd_tick <= (ph == 2'h3);
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & 32'hfffffffc);
  endtask : rchk
  function automatic logic [31:0] mk(logic [1:0] s, logic [6:0] hp, logic [6:0] ll);
    return {11'h0, ll, hp, s, 2'h2};
  endfunction : mk
  task automatic wtick;
    @(posedge pclk);
    while (pfd_tick !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    @(posedge pclk);
    #1;
  endtask : wtick
  task automatic nsum(input int k, output int s);
    s = 0;
    repeat (k) begin
      wtick;
      s += int'(n_inst);
    end
  endtask : nsum
  task automatic dchk(input logic [31:0] w, input int e);
    apb(1'b1, fnd_pkg::ADDR_DIV, w);
    wtick;
    wtick;
    chk("n_inst", e, n_inst);
  endtask : dchk
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("word_accept", 1, word_accept);
    for (int i = 0; i < 4; i++) begin
      rchk("latch reset", 8'(4 * i), 32'h0);
    end
    apb(1'b0, fnd_pkg::ADDR_STAT, 32'h0);
    chk("status", 32'h00400001, rd & 32'h00400001);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 1, perr);
    apb(1'b1, 8'h02, 32'h00ffffff);
    chk("misaligned", 1, perr);
    rchk("ref kept", fnd_pkg::ADDR_REF, 32'h0);
  endtask : t_reset
  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'(4 * i), 32'hffa5c3fc | i);
      rchk("latch rw", 8'(4 * i), 32'h00a5c3fc);
    end
  endtask : t_regs
  task automatic t_serial;
    for (int i = 0; i < 4; i++) begin
      i_mcu.send_word(24'h9d6b54 | 24'(i));
      repeat (3) @(posedge pclk);
      rchk("latch serial", 8'(4 * i), 32'h009d6b54);
    end
  endtask : t_serial
  task automatic t_div;
    int sa, sb;
    apb(1'b1, fnd_pkg::ADDR_MOD, mk(2'h0, 7'h0, 7'h0));
    apb(1'b1, fnd_pkg::ADDR_REF, 32'h0);
    dchk(32'h190001, 100);
    dchk(32'h3fc001, 255);
    dchk(32'h028001, 31);
    dchk(32'h428001, 91);
    apb(1'b1, fnd_pkg::ADDR_DIV, 32'h192001);
    nsum(32, sa);
    chk("n average", 3216, sa);
    apb(1'b1, fnd_pkg::ADDR_REF, 32'h20);
    apb(1'b1, fnd_pkg::ADDR_DIV, 32'h191ffd);
    nsum(32, sa);
    chk("corr plus", 3216, sa);
    apb(1'b1, fnd_pkg::ADDR_REF, 32'h1fe0);
    apb(1'b1, fnd_pkg::ADDR_DIV, 32'h192005);
    nsum(32, sa);
    chk("corr minus", 3216, sa);
    apb(1'b1, fnd_pkg::ADDR_REF, 32'h0);
    apb(1'b1, fnd_pkg::ADDR_DIV, 32'h192001);
    apb(1'b1, fnd_pkg::ADDR_MOD, mk(2'h0, 7'h0, 7'h40));
    i_mcu.set_bit(1'b1);
    nsum(64, sa);
    i_mcu.set_bit(1'b0);
    nsum(64, sb);
    chk("fsk sum", 12864, sa + sb);
    chk("fsk spread", 2, (sa > sb) ? sa - sb : sb - sa);
  endtask : t_div
  task automatic t_mod;
    logic [6:0] e;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, fnd_pkg::ADDR_MOD, mk(2'(s), 7'h55, 7'h2a));
      for (int b = 0; b < 2; b++) begin
        i_mcu.set_bit(b[0]);
        repeat (3) @(posedge pclk);
        #1;
        e = (s == 2 && b == 0) ? 7'h2a : 7'h55;
        chk("pa_enable", (s == 3) ? b : 1, pa_enable);
        if (s != 3 || b == 1) begin
          chk("dac_code", e, dac_code);
        end
      end
    end
  endtask : t_mod
  task automatic t_gfsk;
    int hi, sa, sb;
    hi = 0;
    apb(1'b1, fnd_pkg::ADDR_FUN, 32'hc0b);
    apb(1'b1, fnd_pkg::ADDR_MOD, mk(2'h1, 7'h10, 7'h0) | 32'h40000);
    repeat (12) wtick;
    fork
      begin
        for (int i = 0; i < 8; i++) begin
          i_mcu.send_sync(i[0]);
        end
      end
      begin
        repeat (60) begin
          wtick;
          hi += int'(tx_bit_clock_out === 1'b1);
        end
      end
    join
    chk("bit clock duty", 30, hi);
    // one bit per pfd cycle, top exponent: settled swing is 2^7 / 2^12
    apb(1'b1, fnd_pkg::ADDR_FUN, 32'h407);
    apb(1'b1, fnd_pkg::ADDR_MOD, mk(2'h1, 7'h10, 7'h0) | 32'h1c0000);
    i_mcu.set_bit(1'b1);
    repeat (4) wtick;
    nsum(64, sa);
    i_mcu.set_bit(1'b0);
    repeat (4) wtick;
    nsum(64, sb);
    chk("gfsk dev high", 6434, sa);
    chk("gfsk dev low", 6430, sb);
  endtask : t_gfsk
  task automatic t_fifo;
    int lows;
    lows = 0;
    // the latches drain the buffer at once, so it never refuses a word here
    fork
      i_mcu.send_word(24'h5a3c0f);
      begin
        repeat (60) begin
          @(posedge pclk);
          lows += int'(word_accept !== 1'b1);
        end
      end
    join
    chk("fifo accept", 0, lows);
    rchk("fifo latch", fnd_pkg::ADDR_FUN, 32'h005a3c0c);
    apb(1'b0, fnd_pkg::ADDR_STAT, 32'h0);
    chk("fifo empty", 32'h00000001, rd & 32'h01800001);
    apb(1'b1, fnd_pkg::ADDR_STAT, 32'h1);
    apb(1'b0, fnd_pkg::ADDR_STAT, 32'h0);
    chk("overrun clear", 0, rd[23]);
  endtask : t_fifo
  task automatic conclude;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ph = 2'h0;
    pfd_tick = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    t_reset;
    t_regs;
    t_serial;
    t_div;
    t_mod;
    t_gfsk;
    t_fifo;
    conclude;
  end
  // whole run needs a few thousand cycles; the limit leaves ample slack
  initial begin
    #250000;
    err_count++;
    $display("ERROR watchdog expected done seen hang");
    conclude;
  end
endmodule : tb_top
`default_nettype wire
